//--- logic/ntc_pkg.sv
// Constants shared by the network time counter design
package ntc_pkg;
    // ========================================================
    // Time-base layout
    localparam int NS_W = 32;
    localparam int SUB_W = 20;
    localparam int SEC_W = 48;
    localparam int INC_W = 26;
    localparam int ACC_W = NS_W + SUB_W;
    localparam logic [NS_W-1:0] NS_PER_SEC = 32'h3B9ACA00;
    localparam logic [NS_W-1:0] NS_PER_HALF_8K = 32'h0000F424;
    localparam logic [NS_W-1:0] NS_STEP_MAX = 32'h00000040;
    // ========================================================
    // Clock rate and default increment
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [INC_W-1:0] INC_RESET =
        INC_W'(CLK_PERIOD_NS) << SUB_W;
    // ========================================================
    // Register byte offsets on the APB bus
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_INC = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_NS_OFF = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SEC_OFF_LO = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SEC_OFF_HI = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_NS_NOW = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SEC_NOW_LO = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_SEC_NOW_HI = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_FREE_NS = 8'h1C;
endpackage : ntc_pkg

//--- logic/network_time_counter.sv
// Network time counter with APB register access
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// ============================================================
module network_time_counter
    import ntc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [NS_W-1:0] rtc_ns,
    output logic [SEC_W-1:0] rtc_sec,
    output logic eight_khz_output
);

    // ========================================================
    // Registers
    logic [INC_W-1:0] inc_reg;
    logic [NS_W-1:0] ns_off_reg;
    logic [SEC_W-1:0] sec_off_reg;
    logic [NS_W-1:0] free_ns_reg;
    logic [SUB_W-1:0] free_sub_reg;
    logic [SEC_W-1:0] free_sec_reg;
    logic [NS_W-1:0] sync_ns_reg;
    logic [SEC_W-1:0] sync_sec_reg;
    logic eight_khz_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    logic [ACC_W-1:0] acc_sum;
    logic [NS_W:0] free_ns_raw;
    logic free_wrap;
    logic [NS_W-1:0] free_ns_next;
    logic [SEC_W-1:0] free_sec_next;
    logic [NS_W:0] sync_ns_raw;
    logic sync_wrap;
    logic [NS_W-1:0] sync_ns_next;
    logic [SEC_W-1:0] sync_sec_next;
    logic [NS_W-1:0] slot_next;
    logic setup_phase;
    logic write_hit;
    logic addr_ok;
    logic [31:0] rd_mux;

    // Byte-lane merge for partial APB writes
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // ========================================================
    // Controlled-frequency counter arithmetic
    // Increment is 64 ns at most, so one subtraction covers any wrap
    always_comb begin
        acc_sum = {free_ns_reg, free_sub_reg} + ACC_W'(inc_reg);
        free_ns_raw = {1'b0, acc_sum[ACC_W-1:SUB_W]};
        free_wrap = free_ns_raw >= {1'b0, NS_PER_SEC};
        if (free_wrap) begin
            free_ns_next = NS_W'(free_ns_raw - {1'b0, NS_PER_SEC});
            free_sec_next = free_sec_reg + SEC_W'(1);
        end else begin
            free_ns_next = free_ns_raw[NS_W-1:0];
            free_sec_next = free_sec_reg;
        end
    end

    // Free-running counter, cleared only by reset
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            free_ns_reg <= '0;
            free_sub_reg <= '0;
            free_sec_reg <= '0;
        end else if (clk_en) begin
            free_ns_reg <= free_ns_next;
            free_sub_reg <= acc_sum[SUB_W-1:0];
            free_sec_reg <= free_sec_next;
        end
    end

    // ========================================================
    // Synchronized time: free counter plus software offsets
    // Offset is expected below one second; larger wraps only once
    always_comb begin
        sync_ns_raw = {1'b0, free_ns_reg} + {1'b0, ns_off_reg};
        sync_wrap = sync_ns_raw >= {1'b0, NS_PER_SEC};
        if (sync_wrap) begin
            sync_ns_next = NS_W'(sync_ns_raw - {1'b0, NS_PER_SEC});
        end else begin
            sync_ns_next = sync_ns_raw[NS_W-1:0];
        end
        sync_sec_next = free_sec_reg + sec_off_reg
            + SEC_W'(sync_wrap);
        slot_next = sync_ns_next / NS_PER_HALF_8K;
    end

    // Registered step-2 sums and the 8 kHz phase
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync_ns_reg <= '0;
            sync_sec_reg <= '0;
            eight_khz_reg <= 1'b0;
        end else if (clk_en) begin
            sync_ns_reg <= sync_ns_next;
            sync_sec_reg <= sync_sec_next;
            eight_khz_reg <= slot_next[0];
        end
    end

    // ========================================================
    // APB slave: answer is prepared in setup, no wait states
    assign setup_phase = psel && !penable;
    assign write_hit = psel && penable && pwrite && pready_reg;

    always_comb begin
        addr_ok = 1'b1;
        case (paddr)
            OFS_INC: rd_mux = 32'(inc_reg);
            OFS_NS_OFF: rd_mux = ns_off_reg;
            OFS_SEC_OFF_LO: rd_mux = sec_off_reg[31:0];
            OFS_SEC_OFF_HI: rd_mux = 32'(sec_off_reg[SEC_W-1:32]);
            OFS_NS_NOW: rd_mux = sync_ns_reg;
            OFS_SEC_NOW_LO: rd_mux = sync_sec_reg[31:0];
            OFS_SEC_NOW_HI: rd_mux = 32'(sync_sec_reg[SEC_W-1:32]);
            OFS_FREE_NS: rd_mux = free_ns_reg;
            default: begin
                rd_mux = '0;
                addr_ok = 1'b0;
            end
        endcase
    end

    // Bus answer flops
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (clk_en) begin
            pready_reg <= setup_phase;
            pslverr_reg <= setup_phase && !addr_ok;
            if (setup_phase && !pwrite) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    // Software-writable controls; read-only words ignore writes
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            inc_reg <= INC_RESET;
            ns_off_reg <= '0;
            sec_off_reg <= '0;
        end else if (clk_en && write_hit) begin
            case (paddr)
                OFS_INC: inc_reg <= INC_W'(merge_bytes(
                    32'(inc_reg), pwdata, pstrb));
                OFS_NS_OFF: ns_off_reg <=
                    merge_bytes(ns_off_reg, pwdata, pstrb);
                OFS_SEC_OFF_LO: sec_off_reg[31:0] <=
                    merge_bytes(sec_off_reg[31:0], pwdata, pstrb);
                OFS_SEC_OFF_HI: sec_off_reg[SEC_W-1:32] <= 16'(merge_bytes(
                    32'(sec_off_reg[SEC_W-1:32]), pwdata, pstrb));
                default: ;
            endcase
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign rtc_ns = sync_ns_reg;
    assign rtc_sec = sync_sec_reg;
    assign eight_khz_output = eight_khz_reg;

    // ========================================================
    // Checks on the time base
    property p_free_ns_range;
        @(posedge clk_sys) disable iff (reset)
        free_ns_reg < NS_PER_SEC;
    endproperty
    a_free_ns_range: assert property (p_free_ns_range)
        else $error("free ns reached one second");

    // Sampled reset keeps the release edge, still in reset, out
    property p_free_adv;
        @(posedge clk_sys) disable iff (reset)
        !reset && clk_en && !free_wrap |=>
        {free_ns_reg, free_sub_reg} ==
        $past({free_ns_reg, free_sub_reg}) + ACC_W'($past(inc_reg));
    endproperty
    a_free_adv: assert property (p_free_adv)
        else $error("free counter did not gain increment");

    property p_sec_adv;
        @(posedge clk_sys) disable iff (reset)
        clk_en && free_wrap |=>
        free_sec_reg == $past(free_sec_reg) + SEC_W'(1);
    endproperty
    a_sec_adv: assert property (p_sec_adv)
        else $error("seconds did not advance on wrap");

    property p_sec_wrap;
        @(posedge clk_sys) disable iff (reset)
        clk_en && !free_wrap |=> free_sec_reg == $past(free_sec_reg);
    endproperty
    a_sec_wrap: assert property (p_sec_wrap)
        else $error("seconds changed without ns wrap");

    property p_step_limit;
        @(posedge clk_sys) disable iff (reset)
        clk_en && !free_wrap |=>
        free_ns_reg - $past(free_ns_reg) <= NS_STEP_MAX;
    endproperty
    a_step_limit: assert property (p_step_limit)
        else $error("ns step above 64 ns");

    property p_sync_ns;
        @(posedge clk_sys) disable iff (reset)
        clk_en && !sync_wrap |=>
        sync_ns_reg == $past(free_ns_reg) + $past(ns_off_reg);
    endproperty
    a_sync_ns: assert property (p_sync_ns)
        else $error("synced ns not free plus offset");

    property p_sync_sec;
        @(posedge clk_sys) disable iff (reset)
        clk_en |=> sync_sec_reg == $past(free_sec_reg)
            + $past(sec_off_reg) + SEC_W'($past(sync_wrap));
    endproperty
    a_sync_sec: assert property (p_sync_sec)
        else $error("synced seconds mismatch");

    property p_khz;
        @(posedge clk_sys) disable iff (reset)
        clk_en |=> eight_khz_output ==
            $past(sync_ns_next / NS_PER_HALF_8K) % 2;
    endproperty
    a_khz: assert property (p_khz)
        else $error("8 kHz phase wrong");

    property p_off_write;
        @(posedge clk_sys) disable iff (reset)
        clk_en && write_hit && paddr == OFS_NS_OFF && pstrb == 4'hF
        |=> ns_off_reg == $past(pwdata);
    endproperty
    a_off_write: assert property (p_off_write)
        else $error("ns offset write lost");

    property p_sub_step;
        @(posedge clk_sys) disable iff (reset)
        !reset && clk_en |=>
        free_sub_reg == $past(free_sub_reg) + $past(inc_reg[SUB_W-1:0]);
    endproperty
    a_sub_step: assert property (p_sub_step)
        else $error("fraction did not gain low increment bits");

    // Holds only while software keeps the offset below one second
    property p_sync_range;
        @(posedge clk_sys) disable iff (reset)
        !reset && clk_en && ns_off_reg < NS_PER_SEC |=>
        rtc_ns < NS_PER_SEC;
    endproperty
    a_sync_range: assert property (p_sync_range)
        else $error("synced ns left the one second range");

    property p_khz_hold;
        @(posedge clk_sys) disable iff (reset)
        !reset && clk_en &&
        sync_ns_next / NS_PER_HALF_8K == sync_ns_reg / NS_PER_HALF_8K
        |=> $stable(eight_khz_output);
    endproperty
    a_khz_hold: assert property (p_khz_hold)
        else $error("8 kHz output moved inside one slot");

endmodule : network_time_counter

//--- sim/tb_network_time_counter.sv
// Self-checking bench for the network time counter
`timescale 1ns/1ps
module tb_network_time_counter;
    import ntc_pkg::*;
    // ========================================================
    // Signals
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NS_W-1:0] rtc_ns;
    logic [SEC_W-1:0] rtc_sec;
    logic eight_khz_output;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int checks = 0;
    // ========================================================
    // Design under test
    network_time_counter dut_u (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rtc_ns(rtc_ns),
        .rtc_sec(rtc_sec),
        .eight_khz_output(eight_khz_output)
    );
    // 100 MHz reference clock
    always #5 clk_sys = ~clk_sys;
    // ========================================================
    // Shared tasks
    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    // Values read right after an edge are the ones the edge sampled
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 20) begin
                fails++;
                report_and_stop();
            end
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // ========================================================
    // Scenarios
    task automatic t_reset;
        check("rtc_ns", 64'(rtc_ns), 64'h0);
        check("rtc_sec", 64'(rtc_sec), 64'h0);
        check("khz_rst", 64'(eight_khz_output), 64'h0);
        reset <= 1'b0;
        apb(1'b0, OFS_INC, 32'h0);
        check("inc_rst", 64'(rd), 64'(INC_RESET));
        apb(1'b0, OFS_NS_OFF, 32'h0);
        check("off_rst", 64'(rd), 64'h0);
    endtask : t_reset
    // Offset is zero here, so the synced step equals the free step
    task automatic rate(input logic [31:0] inc, input int k,
                        input logic [31:0] exp);
        logic [31:0] a;
        apb(1'b1, OFS_INC, inc);
        cyc(3);
        a = rtc_ns;
        cyc(k);
        check("ns_step", 64'(rtc_ns - a), 64'(exp));
    endtask : rate
    // Seconds at all ones, then a forced nanosecond wrap
    task automatic t_wrap;
        logic [31:0] p;
        apb(1'b1, OFS_SEC_OFF_LO, 32'hFFFFFFFF);
        apb(1'b1, OFS_SEC_OFF_HI, 32'h0000FFFF);
        apb(1'b0, OFS_FREE_NS, 32'h0);
        apb(1'b1, OFS_NS_OFF, NS_PER_SEC - rd - 32'd3000);
        cyc(2);
        check("sec_max", 64'(rtc_sec), 64'hFFFFFFFFFFFF);
        repeat (60) begin
            p = rtc_ns;
            @(posedge clk_sys);
            check("khz", 64'(eight_khz_output),
                64'((rtc_ns / 32'd62500) % 2));
            if (rtc_ns < p) begin
                check("ns_wrap", 64'(rtc_ns),
                    64'(p + 32'd63 - NS_PER_SEC));
                check("sec_wrap", 64'(rtc_sec), 64'h0);
            end else begin
                check("step63", 64'(rtc_ns - p), 64'd63);
            end
        end
    endtask : t_wrap
    task automatic t_bus;
        apb(1'b1, 8'h20, 32'h12345678);
        check("wr_err", 64'(err), 64'h1);
        apb(1'b0, 8'h20, 32'h0);
        check("rd_err", 64'({err, rd}), 64'h100000000);
        apb(1'b1, OFS_NS_NOW, 32'h0);
        check("ro_err", 64'(err), 64'h0);
        // Only the second byte lane may land
        apb(1'b1, OFS_NS_OFF, 32'h0);
        pstrb <= 4'h2;
        apb(1'b1, OFS_NS_OFF, 32'hAAAA12AA);
        pstrb <= 4'hF;
        apb(1'b0, OFS_NS_OFF, 32'h0);
        check("strb", 64'(rd), 64'h00001200);
    endtask : t_bus
    // Clock enable low must freeze rtc_ns; only rtc_ns is checked, over three cycles
    task automatic t_hold;
        logic [31:0] a;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        cyc(2);
        a = rtc_ns;
        cyc(3);
        check("frozen", 64'(rtc_ns), 64'(a));
        clk_en <= 1'b1;
    endtask : t_hold
    // ========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        t_reset();
        rate(32'h00A00000, 1, 32'd10);
        rate(32'h00180000, 2, 32'd3);
        rate(32'h00080000, 4, 32'd2);
        rate(32'hFFF00000, 1, 32'd63);
        apb(1'b0, OFS_INC, 32'h0);
        check("inc_width", 64'(rd), 64'h03F00000);
        t_wrap();
        t_bus();
        t_hold();
        report_and_stop();
    end
endmodule : tb_network_time_counter
